//--- bench/cmt_cpu_model.sv
/*
 * Bus side partner of the timer: a CPU model issuing APB transfers.
 * Assumes the timer answers with pready; waits are cut by the watchdog.
 */
`timescale 1ns/1ps
module cmt_cpu_model (
    input  wire logic        mclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'h0;
    end

    // Reserved bits and the flag are only ever sent as zero by software
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

//--- bench/cmt_timer_checker.sv
/*
 * Port checker for the timer: bus timing, reserved bits, interrupt line.
 * Assumes the fixed transfer lengths of the timer's bus slave.
 */
`timescale 1ns/1ps
module cmt_timer_checker #(
    parameter int ADDR_W = 12
) (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              manualRst,
    input  wire logic              standby,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr,
    input  wire logic [1:0]        matchIrqRequest
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire logic setup = psel && !penable;
    wire logic mapped = paddr inside {12'hC40, 12'hC48, 12'hC50, 12'hC58,
                                      12'hC60, 12'hC68, 12'hC70};
    wire logic rdDone = pready && !pwrite;

    property p_rdTime; setup && !pwrite |-> ##3 pready; endproperty
    property p_shortWr;
        setup && pwrite && pstrb != 4'hF |-> ##1 !pready[*2] ##1 pready;
    endproperty
    property p_longWr;
        setup && pwrite && pstrb == 4'hF |-> ##1 !pready[*6] ##1 pready;
    endproperty
    property p_onePulse; pready |=> !pready; endproperty
    property p_errMap; pready |-> pslverr == !mapped; endproperty
    property p_runRsv; rdDone && paddr == 12'hC40 |-> prdata[31:2] == 0;
    endproperty
    property p_csrRsv; rdDone && (paddr == 12'hC48 || paddr == 12'hC60)
        |-> prdata[31:8] == 0 && prdata[5:2] == 0; endproperty
    property p_irqEn; rdDone && paddr == 12'hC48 && !prdata[6]
        |-> !matchIrqRequest[0]; endproperty
    property p_standby; standby[*2] |-> ##1 matchIrqRequest == 2'b00;
    endproperty

    a_rdTime: assert property (p_rdTime) else $error("read answer late");
    a_shortWr: assert property (p_shortWr) else $error("short write");
    a_longWr: assert property (p_longWr) else $error("long write");
    a_onePulse: assert property (p_onePulse) else $error("pready long");
    a_errMap: assert property (p_errMap) else $error("slverr wrong");
    a_runRsv: assert property (p_runRsv) else $error("run reserved");
    a_csrRsv: assert property (p_csrRsv) else $error("csr reserved");
    a_irqEn: assert property (p_irqEn) else $error("irq when masked");
    a_standby: assert property (p_standby) else $error("irq in standby");

    c_err: cover property (pready && pslverr);
    c_irq: cover property ($rose(matchIrqRequest[0]));
    c_stby: cover property (standby[*2]);
endmodule

bind cmt_timer cmt_timer_checker #(.ADDR_W(ADDR_W)) i_cmt_timer_checker (
    .mclk(mclk), .rstn(rstn), .manualRst(manualRst), .standby(standby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .matchIrqRequest(matchIrqRequest));

//--- bench/tb.sv
/*
 * Self-checking bench for the timer: reset values, access, counting,
 * match flag and interrupt, manual reset and standby.
 * Assumes the CPU model for all bus traffic.
 */
`timescale 1ns/1ps
module tb;
    import cmt_pkg::*;
    logic mclk = 1'b0, rstn = 1'b0, manualRst = 1'b0, standby = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [1:0] irq;
    int err_total = 0, samples_checked = 0;
    always #20 mclk = ~mclk;

    cmt_timer i_cmt_timer (.mclk(mclk), .rstn(rstn), .manualRst(manualRst),
        .standby(standby), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .matchIrqRequest(irq));
    cmt_cpu_model i_cmt_cpu_model (.mclk(mclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    function automatic logic [11:0] ad(input logic [31:0] idx);
        return {idx[9:0], 2'b00};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] idx, input logic [15:0] d,
                      input logic [3:0] s);
        logic [31:0] r;
        logic e;
        i_cmt_cpu_model.xfer(1'b1, ad(idx), {16'h0000, d}, s, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        i_cmt_cpu_model.xfer(1'b0, a, 32'h0000_0000, 4'h0, r, e);
        chk({31'h0000_0000, e}, {31'h0000_0000, !(a inside {12'hC40, 12'hC48,
            12'hC50, 12'hC58, 12'hC60, 12'hC68, 12'hC70})});
    endtask
    task automatic rdc(input logic [31:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        rd(ad(idx), r);
        chk(r, exp);
    endtask
    task automatic conclude;
        if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic t_reset;
        rdc(IDX_RUN, 32'h0000_0000);
        for (int c = 0; c < 2; c++) begin
            rdc(IDX_CSR[c], 32'h0000_0000);
            rdc(IDX_CNT[c], 32'h0000_0000);
            rdc(IDX_COR[c], 32'h0000_FFFF);
        end
    endtask
    task automatic t_access;
        logic [31:0] r;
        wr(IDX_RUN, 16'h0003, 4'h3);
        rdc(IDX_RUN, 32'h0000_0003);
        wr(IDX_RUN, 16'h0000, 4'h3);
        wr(IDX_COR[0], 16'h1234, 4'hF);
        rdc(IDX_COR[0], 32'h0000_1234);
        wr(IDX_COR[0], 16'h5600, 4'h2);
        rdc(IDX_COR[0], 32'h0000_5634);
        wr(IDX_CSR[1], 16'h0043, 4'h3);
        rdc(IDX_CSR[1], 32'h0000_0043);
        wr(IDX_CSR[1], 16'h0000, 4'h3);
        wr(IDX_CNT[1], 16'h1234, 4'h3);
        wr(IDX_CNT[1], 16'hAB00, 4'h2);
        rdc(IDX_CNT[1], 32'h0000_AB34);
        rd(12'h004, r);
        chk(r, 32'h0000_0000);
    endtask
    task automatic t_count;
        logic [31:0] r;
        for (int s = 0; s < 4; s++) begin
            wr(IDX_CNT[1], 16'h0000, 4'h3);
            wr(IDX_CSR[1], 16'(s), 4'h1);
            wr(IDX_RUN, 16'h0002, 4'h1);
            repeat (4 * (8 << (2 * s))) @(posedge mclk);
            wr(IDX_RUN, 16'h0000, 4'h1);
            rd(ad(IDX_CNT[1]), r);
            chk({31'h0, r === 32'h4 || r === 32'h5}, 32'h1);
        end
    endtask
    task automatic t_match;
        wr(IDX_CNT[0], 16'h0000, 4'h3);
        wr(IDX_COR[0], 16'h0003, 4'h3);
        wr(IDX_CSR[0], 16'h0040, 4'h1);
        wr(IDX_RUN, 16'h0001, 4'h1);
        repeat (300) begin
            @(posedge mclk);
            if (irq[0] === 1'b1) break;
        end
        chk({30'h0, irq}, 32'h1);
        wr(IDX_RUN, 16'h0000, 4'h1);
        wr(IDX_CSR[0], 16'h0040, 4'h1);
        rdc(IDX_CSR[0], 32'h0000_00C0);
        wr(IDX_CSR[0], 16'h0040, 4'h1);
        rdc(IDX_CSR[0], 32'h0000_0040);
        chk({30'h0, irq}, 32'h0);
    endtask
    task automatic t_resets;
        wr(IDX_COR[0], 16'h00AA, 4'h3);
        wr(IDX_RUN, 16'h0001, 4'h1);
        @(posedge mclk) manualRst <= 1'b1;
        repeat (3) @(posedge mclk);
        manualRst <= 1'b0;
        rdc(IDX_COR[0], 32'h0000_00AA);
        rdc(IDX_RUN, 32'h0000_0001);
        @(posedge mclk) standby <= 1'b1;
        repeat (2) @(posedge mclk);
        standby <= 1'b0;
        rdc(IDX_COR[0], 32'h0000_FFFF);
        rdc(IDX_RUN, 32'h0000_0000);
        rdc(IDX_CSR[0], 32'h0000_0000);
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_access();
        t_count();
        t_match();
        t_resets();
        conclude();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        conclude();
    end
endmodule

//--- core/cmt_pkg.sv
/*
 * Constants for the two-channel compare match interval timer: register
 * indices, field positions, reset values, prescaler masks and bus timing.
 * Assumes an APB slave whose byte address is four times a register index.
 */
package cmt_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address = 4 * index, low IDX_W bits decoded)
    // ------------------------------------------------------------------
    localparam int          IDX_W   = 10;
    localparam int          ADDR_W  = IDX_W + 2;
    localparam logic [31:0] IDX_RUN = 32'hFFFF_F710;
    localparam logic [31:0] IDX_CSR [0:1] = '{32'hFFFF_F712, 32'hFFFF_F718};
    localparam logic [31:0] IDX_CNT [0:1] = '{32'hFFFF_F714, 32'hFFFF_F71A};
    localparam logic [31:0] IDX_COR [0:1] = '{32'hFFFF_F716, 32'hFFFF_F71C};

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int          CNT_W     = 16;
    localparam int          BIT_FLAG  = 7;
    localparam int          BIT_IE    = 6;
    localparam int          SEL_LO    = 0;
    localparam int          SEL_HI    = 1;
    localparam logic [15:0] RST_CNT   = 16'h0000;
    localparam logic [15:0] RST_COR   = 16'hFFFF;
    localparam logic [1:0]  RST_RUN   = 2'h0;
    localparam logic [1:0]  RST_SEL   = 2'h0;

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    localparam int          PRE_W     = 9;
    localparam logic [8:0]  PRE_M8    = 9'h007;
    localparam logic [8:0]  PRE_M32   = 9'h01F;
    localparam logic [8:0]  PRE_M128  = 9'h07F;
    localparam logic [8:0]  PRE_M512  = 9'h1FF;
    localparam logic [1:0]  SEL_D8    = 2'h0;
    localparam logic [1:0]  SEL_D32   = 2'h1;
    localparam logic [1:0]  SEL_D128  = 2'h2;

    // ------------------------------------------------------------------
    // Bus timing: whole transfer length in cycles, setup included
    // ------------------------------------------------------------------
    localparam logic [3:0]  XFER_SHORT = 4'h4;
    localparam logic [3:0]  XFER_LONG  = 4'h8;
    localparam logic [3:0]  WAIT_SHORT = XFER_SHORT - 4'h3;
    localparam logic [3:0]  WAIT_LONG  = XFER_LONG - 4'h3;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01,
        BUS_DONE = 2'b10
    } cmt_bus_e;

endpackage

//--- core/cmt_timer.sv
/*
 * Two-channel compare match interval timer with an APB register slave.
 * Assumes one clock mclk, a power-on reset rstn, and standby and manual
 * reset levels that come from logic on the same clock.
 */
`timescale 1ns/1ps
module cmt_timer #(
    parameter int ADDR_W = cmt_pkg::ADDR_W
) (
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire logic                 manualRst,
    input  wire logic                 standby,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic      [1:0]           matchIrqRequest
);
    import cmt_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [1:0]            runReg;
    logic [1:0]            flagReg;
    logic [1:0]            ieReg;
    logic [1:0]            armReg;
    logic [1:0][1:0]       selReg;
    logic [1:0][CNT_W-1:0] cntReg;
    logic [1:0][CNT_W-1:0] corReg;
    logic [PRE_W-1:0]      preReg;
    cmt_bus_e              busReg;
    logic [3:0]            waitReg;
    logic [31:0]           prdataReg;
    logic                  preadyReg;
    logic                  slverrReg;
    logic [1:0]            irqReg;

    // ------------------------------------------------------------------
    // Decode and control nets
    // ------------------------------------------------------------------
    logic [ADDR_W-3:0]     idx;
    logic                  hitRun;
    logic [1:0]            hitCsr;
    logic [1:0]            hitCnt;
    logic [1:0]            hitCor;
    logic                  mapped;
    logic [31:0]           rdata;
    logic                  done;
    logic                  wrDone;
    logic                  rdDone;
    logic [15:0]           wMask;
    logic [3:0]            waitTarget;
    logic [1:0]            tick;
    logic [1:0]            matchEv;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Index match on the decoded low bits
    function automatic logic hit(input logic [ADDR_W-3:0] a,
                                 input logic [31:0] off);
        hit = (a == off[ADDR_W-3:0]);
    endfunction

    // Pulse when the selected low prescaler bits are all ones
    function automatic logic tickOf(input logic [PRE_W-1:0] pre,
                                    input logic [1:0] sel);
        logic [PRE_W-1:0] m;
        case (sel)
            SEL_D8:   m = PRE_M8;
            SEL_D32:  m = PRE_M32;
            SEL_D128: m = PRE_M128;
            default:  m = PRE_M512;
        endcase
        tickOf = ((pre & m) == m);
    endfunction

    // Byte merge keeps unstrobed bytes untouched
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [15:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    // ------------------------------------------------------------------
    // Address decode and read mux
    // ------------------------------------------------------------------
    always_comb begin
        // Only the low index bits are decoded; upper bits alias
        idx    = paddr[ADDR_W-1:2];
        hitRun = hit(idx, IDX_RUN);
        for (int c = 0; c < 2; c++) begin
            hitCsr[c] = hit(idx, IDX_CSR[c]);
            hitCnt[c] = hit(idx, IDX_CNT[c]);
            hitCor[c] = hit(idx, IDX_COR[c]);
        end
        mapped = hitRun | (|hitCsr) | (|hitCnt) | (|hitCor);
    end

    always_comb begin
        // Unmapped and reserved bits read as zero
        rdata = 32'h0000_0000;
        if (hitRun) begin
            rdata[1:0] = runReg;
        end
        for (int c = 0; c < 2; c++) begin
            if (hitCsr[c]) begin
                rdata[BIT_FLAG]      = flagReg[c];
                rdata[BIT_IE]        = ieReg[c];
                rdata[SEL_HI:SEL_LO] = selReg[c];
            end
            // Counter and period read back as full 16 bits
            if (hitCnt[c]) begin
                rdata[15:0] = cntReg[c];
            end
            if (hitCor[c]) begin
                rdata[15:0] = corReg[c];
            end
        end
    end

    // A transfer completes on the edge that sees pready high
    assign done   = psel & penable & preadyReg;
    assign wrDone = done & pwrite & mapped;
    assign rdDone = done & ~pwrite & mapped;
    assign wMask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    // Only a full-strobe write counts as a longword access
    assign waitTarget = (pwrite && pstrb == 4'hF) ? WAIT_LONG
                                                  : WAIT_SHORT;

    // ------------------------------------------------------------------
    // APB transfer timing
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busReg    <= BUS_IDLE;
            waitReg   <= 4'h0;
            preadyReg <= 1'b0;
            slverrReg <= 1'b0;
            prdataReg <= 32'h0000_0000;
        end else begin
            case (busReg)
                BUS_IDLE: begin
                    waitReg <= 4'h0;
                    if (psel && !penable) begin
                        busReg <= BUS_WAIT;
                    end
                end
                BUS_WAIT: begin
                    // Count access cycles; answer once the target is hit
                    if (waitReg == waitTarget) begin
                        busReg    <= BUS_DONE;
                        preadyReg <= 1'b1;
                        slverrReg <= ~mapped;
                        // Write cycles return zero data
                        prdataReg <= pwrite ? 32'h0000_0000 : rdata;
                    end else begin
                        waitReg <= waitReg + 4'h1;
                    end
                end
                BUS_DONE: begin
                    busReg    <= BUS_IDLE;
                    preadyReg <= 1'b0;
                    slverrReg <= 1'b0;
                    waitReg   <= 4'h0;
                end
                default: begin
                    busReg    <= BUS_IDLE;
                    preadyReg <= 1'b0;
                    slverrReg <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Prescaler, free running; manual reset restarts its phase only
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            preReg <= '0;
        end else if (standby || manualRst) begin
            preReg <= '0;
        end else begin
            // Ticks are enables in the mclk domain, not derived clocks
            preReg <= preReg + PRE_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Shared run register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            runReg <= RST_RUN;
        end else if (standby) begin
            // Standby clears the run bits like power-on reset
            runReg <= RST_RUN;
        end else if (wrDone && hitRun && pstrb[0]) begin
            runReg <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic clrFlag;
        logic csrWr;

        // Count enable for this channel, gated by its run bit
        assign tick[c]    = runReg[c] & tickOf(preReg, selReg[c]);
        // Match acts only on a tick, so the flag waits for one
        assign matchEv[c] = tick[c] & (cntReg[c] == corReg[c]);
        assign csrWr      = wrDone & hitCsr[c] & pstrb[0];
        assign clrFlag    = csrWr & ~pwdata[BIT_FLAG] & armReg[c];

        // --------------------------------------------------------------
        // Counter; manual reset has no effect here
        // --------------------------------------------------------------
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                cntReg[c] <= RST_CNT;
            end else if (standby) begin
                cntReg[c] <= RST_CNT;
            end else if (matchEv[c]) begin
                cntReg[c] <= RST_CNT;
            end else if (wrDone && hitCnt[c]) begin
                cntReg[c] <= merge(cntReg[c], pwdata[15:0],
                                   wMask);
            end else if (tick[c]) begin
                cntReg[c] <= cntReg[c] + 16'h0001;
            end
        end

        // --------------------------------------------------------------
        // Period constant; manual reset has no effect here
        // --------------------------------------------------------------
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                corReg[c] <= RST_COR;
            end else if (standby) begin
                corReg[c] <= RST_COR;
            end else if (wrDone && hitCor[c]) begin
                corReg[c] <= merge(corReg[c], pwdata[15:0], wMask);
            end
        end

        // --------------------------------------------------------------
        // Control/status: flag set wins over a coinciding clear
        // --------------------------------------------------------------
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                flagReg[c] <= 1'b0;
                armReg[c]  <= 1'b0;
                ieReg[c]   <= 1'b0;
                selReg[c]  <= RST_SEL;
            end else if (standby) begin
                flagReg[c] <= 1'b0;
                armReg[c]  <= 1'b0;
                ieReg[c]   <= 1'b0;
                selReg[c]  <= RST_SEL;
            end else begin
                if (matchEv[c]) begin
                    flagReg[c] <= 1'b1;
                end else if (clrFlag) begin
                    flagReg[c] <= 1'b0;
                end
                // Arm only on a completed read that returned the flag set
                if (rdDone && hitCsr[c] && prdataReg[BIT_FLAG]) begin
                    armReg[c] <= 1'b1;
                end else if (csrWr) begin
                    armReg[c] <= 1'b0;
                end
                if (csrWr) begin
                    ieReg[c]  <= pwdata[BIT_IE];
                    selReg[c] <= pwdata[SEL_HI:SEL_LO];
                end
            end
        end

        // --------------------------------------------------------------
        // One request line per channel, taken from a flop
        // --------------------------------------------------------------
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                irqReg[c] <= 1'b0;
            end else begin
                irqReg[c] <= flagReg[c] & ieReg[c];
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata          = prdataReg;
    assign pready          = preadyReg;
    assign pslverr         = slverrReg;
    assign matchIrqRequest = irqReg;

endmodule
